// >>> rtl/cwl_top.sv
// clock control, watchdog and low-power mode controller with wishbone slave
//
// Contract
// - limp clock keeps core running on loss when pll enabled and ratio nonzero
// - watchdog counter frozen while input clock lost
// - four-bit ratio field selects core rate
// - disable pin low at reset: core equals input
// - default bypass gives input clock over two
// - nonzero ratio n gives input times n halved
// - counter maximum drives reset low 512 oscillator clocks
// - key 0x55 then 0xaa clears watchdog counter
// - watchdog interrupt can wake from standby
// - watchdog interrupt leaves idle via expander
// - halt stops oscillator, pll and watchdog
// - select 00 idle, 01 standby, 1x halt
// - idle keeps all clocks, controller does nothing
// - idle exits on enabled interrupt or nmi
// - standby stops core and peripherals, watchdog runs
// - wake qualified over programmed oscillator clocks in standby, system clocks in halt
// - short low pulse returns to low power
// - only reset or nmi leave halt
// - output pins hold state in low power
// - codes 0 bypass, 1-10 multiply, 11-15 reserved
// - only external reset clears the ratio
`include "cwl_regs.svh"
module cwl_top #(
  parameter int SETTLE_CYC = `CWL_SETTLE_CYC,
  parameter int PULSE_LEN  = `CWL_WD_PULSE
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              dbg_reset_in,
  input  wire logic              cyc_in,
  input  wire logic              stb_in,
  input  wire logic              we_in,
  input  wire logic [4:0]        adr_in,
  input  wire logic [3:0]        sel_in,
  input  wire logic [31:0]       dat_in,
  output logic      [31:0]       dat_out,
  output logic                   ack_out,
  input  wire logic              pll_disable_pin_n_in,
  input  wire logic              osc_tick_in,
  input  wire logic              clock_lost_in,
  input  wire logic              idle_exec_in,
  input  wire logic              irq_pending_in,
  input  wire logic              ext_nonmaskable_irq_n_in,
  input  wire cwl_pkg::cwl_wake_s wake_in,
  output logic                   system_clock_out,
  output logic      [3:0]        sysclk_halves_out,
  output logic                   limp_mode_out,
  output logic                   osc_run_out,
  output logic                   periph_run_out,
  output logic                   pin_hold_out,
  output logic                   pll_settled_out,
  output logic                   wdog_reset_out_n,
  output logic                   wdog_wake_irq_n,
  output logic                   wdog_irq_to_expander_out,
  output logic                   wake_out,
  output logic      [1:0]        lpm_state_out
);
  cwl_pkg::cwl_lpm_e state_reg;
  logic [3:0]  pll_ratio_reg;
  logic        pll_dis_reg;
  logic [7:0]  lowpower_ctrl_a;
  logic [15:0] wake_select_reg;
  logic [1:0]  wdctrl_reg;
  logic [7:0]  wd_cnt_reg;
  logic        key_armed_reg;
  logic [9:0]  pulse_cnt_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [5:0]  qual_cnt_reg;
  logic [7:0]  limp_cnt_reg;
  logic [17:0] settle_cnt_reg;
  logic        limp_tick;
  logic        wr_en;
  logic        wd_clr;
  logic        wd_run;
  logic        wd_hit;
  logic        running;
  logic        wake_low;
  logic        qual_tick;
  logic [15:0] wake_vec_n;
  logic [1:0]  lowpower_select;
  logic [5:0]  qual_len;

  // bus write strobe: a write takes effect on the acknowledge edge
  assign wr_en   = cyc_in && stb_in && we_in && ack_reg && sel_in[0];
  assign ack_out = ack_reg;
  assign dat_out = rdat_reg;
  assign lowpower_select = lowpower_ctrl_a[`CWL_LPSEL_LSB +: 2];
  assign qual_len = (lowpower_ctrl_a[`CWL_QUAL_LSB +: 6] == 6'h00) ? 6'h01
                  : lowpower_ctrl_a[`CWL_QUAL_LSB +: 6];

  // acknowledge one cycle after request, dropped the cycle after
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_in && stb_in && !ack_reg;
    end
  end

  // read data, unmapped words read zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdat_reg <= 32'h0000_0000;
    end else if (cyc_in && stb_in && !ack_reg) begin
      case (adr_in[4:2])
        `CWL_ADR_PLL:     rdat_reg <= {28'h0000000, pll_ratio_reg};
        `CWL_ADR_LPCTRL:  rdat_reg <= {24'h000000, lowpower_ctrl_a};
        `CWL_ADR_WAKESEL: rdat_reg <= {16'h0000, wake_select_reg};
        `CWL_ADR_WDCTRL:  rdat_reg <= {30'h0, wdctrl_reg};
        `CWL_ADR_WDCNT:   rdat_reg <= {24'h000000, wd_cnt_reg};
        `CWL_ADR_STATUS:  rdat_reg <= {26'h0, pll_settled_out, limp_mode_out,
                                       pll_dis_reg, key_armed_reg, lpm_state_out};
        default:          rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // disable pin caught while external reset holds
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pll_dis_reg <= !pll_disable_pin_n_in;
    end
  end

  // ratio survives debugger reset; reserved codes not taken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pll_ratio_reg <= `CWL_RATIO_RST;
    end else if (wr_en && adr_in[4:2] == `CWL_ADR_PLL
                 && dat_in[3:0] <= `CWL_RATIO_MAX) begin
      pll_ratio_reg <= dat_in[3:0];
    end
  end

  // core rate in halves of the input clock
  always_comb begin
    if (pll_dis_reg) begin
      sysclk_halves_out = 4'h2;
    end else if (pll_ratio_reg == 4'h0) begin
      sysclk_halves_out = 4'h1;
    end else begin
      sysclk_halves_out = pll_ratio_reg;
    end
  end

  // pll settle time after each ratio write
  always_ff @(posedge clk_in) begin
    if (rst_in || dbg_reset_in) begin
      settle_cnt_reg <= 18'h00000;
    end else if (wr_en && adr_in[4:2] == `CWL_ADR_PLL) begin
      settle_cnt_reg <= 18'h00000;
    end else if (osc_tick_in && 32'(settle_cnt_reg) < SETTLE_CYC) begin
      settle_cnt_reg <= settle_cnt_reg + 18'h00001;
    end
  end
  assign pll_settled_out = 32'(settle_cnt_reg) >= SETTLE_CYC;

  // limp oscillator divider
  always_ff @(posedge clk_in) begin
    if (rst_in || limp_tick) begin
      limp_cnt_reg <= 8'h00;
    end else begin
      limp_cnt_reg <= limp_cnt_reg + 8'h01;
    end
  end
  assign limp_tick = limp_cnt_reg == 8'(`CWL_LIMP_DIV - 1);

  // core clock pulses, limp source when input lost, pll on and ratio nonzero
  assign running = state_reg == cwl_pkg::CWL_NORMAL || state_reg == cwl_pkg::CWL_IDLE;
  assign limp_mode_out = clock_lost_in && !pll_dis_reg && pll_ratio_reg != 4'h0;
  assign system_clock_out = running && (limp_mode_out ? limp_tick
                                        : (osc_tick_in && !clock_lost_in));
  assign periph_run_out = running;
  assign osc_run_out = state_reg != cwl_pkg::CWL_HALT;
  assign pin_hold_out = state_reg != cwl_pkg::CWL_NORMAL;
  assign lpm_state_out = state_reg;

  // watchdog control and key sequence
  assign wd_clr = wr_en && adr_in[4:2] == `CWL_ADR_WDKEY
                  && dat_in[7:0] == `CWL_KEY_FIRE && key_armed_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in || dbg_reset_in) begin
      wdctrl_reg <= `CWL_WDCTRL_RST;
      key_armed_reg <= 1'b0;
    end else begin
      if (wr_en && adr_in[4:2] == `CWL_ADR_WDCTRL) begin
        wdctrl_reg <= dat_in[1:0];
      end
      if (wr_en && adr_in[4:2] == `CWL_ADR_WDKEY) begin
        key_armed_reg <= dat_in[7:0] == `CWL_KEY_ARM;
      end
    end
  end

  // up counter on oscillator clock, frozen on loss and in halt
  assign wd_run = wdctrl_reg[`CWL_WD_EN_BIT] && osc_tick_in && !clock_lost_in
                  && state_reg != cwl_pkg::CWL_HALT;
  assign wd_hit = wd_run && wd_cnt_reg == `CWL_WD_MAX && !wd_clr;
  always_ff @(posedge clk_in) begin
    if (rst_in || dbg_reset_in || wd_clr) begin
      wd_cnt_reg <= 8'h00;
    end else if (wd_run) begin
      wd_cnt_reg <= wd_cnt_reg + 8'h01;
    end
  end

  // expiry pulse, 512 oscillator clocks, reset or wake interrupt
  always_ff @(posedge clk_in) begin
    if (rst_in || dbg_reset_in) begin
      pulse_cnt_reg <= 10'h000;
    end else if (wd_hit) begin
      pulse_cnt_reg <= 10'(PULSE_LEN);
    end else if (pulse_cnt_reg != 10'h000 && osc_tick_in && !clock_lost_in
                 && state_reg != cwl_pkg::CWL_HALT) begin
      pulse_cnt_reg <= pulse_cnt_reg - 10'h001;
    end
  end
  assign wdog_reset_out_n = !(pulse_cnt_reg != 10'h000 && !wdctrl_reg[`CWL_WD_IRQ_BIT]);
  assign wdog_wake_irq_n = !(pulse_cnt_reg != 10'h000 && wdctrl_reg[`CWL_WD_IRQ_BIT]);
  assign wdog_irq_to_expander_out = !wdog_wake_irq_n;

  // low-power control registers
  always_ff @(posedge clk_in) begin
    if (rst_in || dbg_reset_in) begin
      lowpower_ctrl_a <= `CWL_LPCTRL_RST;
      wake_select_reg <= `CWL_WAKESEL_RST;
    end else begin
      if (wr_en && adr_in[4:2] == `CWL_ADR_LPCTRL) begin
        lowpower_ctrl_a <= dat_in[7:0];
      end
      if (wr_en && adr_in[4:2] == `CWL_ADR_WAKESEL && sel_in[1]) begin
        wake_select_reg <= dat_in[15:0];
      end
    end
  end

  // wake candidates, all active low; standby uses select mask
  assign wake_vec_n = {ext_nonmaskable_irq_n_in, wdog_wake_irq_n, wake_in};
  always_comb begin
    wake_low = 1'b0;
    case (state_reg)
      cwl_pkg::CWL_STANDBY: wake_low = |(~wake_vec_n & wake_select_reg);
      cwl_pkg::CWL_HALT:    wake_low = !ext_nonmaskable_irq_n_in;
      default:              wake_low = 1'b0;
    endcase
  end
  // oscillator is off in halt, so qualify there on the system clock
  assign qual_tick = state_reg == cwl_pkg::CWL_HALT || osc_tick_in;

  // qualifier: count held-low clocks, restart when released
  always_ff @(posedge clk_in) begin
    if (rst_in || dbg_reset_in || !wake_low) begin
      qual_cnt_reg <= 6'h00;
    end else if (qual_tick && qual_cnt_reg != qual_len) begin
      qual_cnt_reg <= qual_cnt_reg + 6'h01;
    end
  end

  // low-power mode sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in || dbg_reset_in) begin
      state_reg <= cwl_pkg::CWL_NORMAL;
      wake_out <= 1'b0;
    end else begin
      wake_out <= 1'b0;
      case (state_reg)
        cwl_pkg::CWL_NORMAL: begin
          if (idle_exec_in) begin
            if (lowpower_select[1]) begin
              state_reg <= cwl_pkg::CWL_HALT;
            end else if (lowpower_select[0]) begin
              state_reg <= cwl_pkg::CWL_STANDBY;
            end else begin
              state_reg <= cwl_pkg::CWL_IDLE;
            end
          end
        end
        cwl_pkg::CWL_IDLE: begin
          if (irq_pending_in || !ext_nonmaskable_irq_n_in || !wdog_wake_irq_n) begin
            state_reg <= cwl_pkg::CWL_NORMAL;
            wake_out <= 1'b1;
          end
        end
        default: begin
          if (wake_low && qual_cnt_reg == qual_len) begin
            state_reg <= cwl_pkg::CWL_NORMAL;
            wake_out <= 1'b1;
          end
        end
      endcase
    end
  end

  // checks
  AST_LIMP: assert property (@(posedge clk_in) disable iff (rst_in)
    (clock_lost_in && pll_ratio_reg != 4'h0 && !pll_dis_reg && running && limp_tick)
    |-> system_clock_out) else $error("limp clock missing");
  AST_WD_FREEZE: assert property (@(posedge clk_in) disable iff (rst_in)
    (clock_lost_in && !wd_clr && !dbg_reset_in) |=> $stable(wd_cnt_reg))
    else $error("watchdog moved on lost clock");
  AST_RATIO: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en && adr_in[4:2] == `CWL_ADR_PLL && dat_in[3:0] != 4'h0
     && dat_in[3:0] <= `CWL_RATIO_MAX && !pll_dis_reg)
    |=> sysclk_halves_out == $past(dat_in[3:0])) else $error("ratio not applied");
  AST_RESERVED: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en && dat_in[3:0] > `CWL_RATIO_MAX) |=> $stable(pll_ratio_reg))
    else $error("reserved ratio taken");
  AST_PLLDIS: assert property (@(posedge clk_in) disable iff (rst_in)
    pll_dis_reg |-> sysclk_halves_out == 4'h2) else $error("disabled pll rate");
  AST_BYPASS: assert property (@(posedge clk_in) disable iff (rst_in)
    (!pll_dis_reg && pll_ratio_reg == 4'h0) |-> sysclk_halves_out == 4'h1)
    else $error("bypass rate wrong");
  AST_WD_PULSE: assert property (@(posedge clk_in) disable iff (rst_in || dbg_reset_in)
    (wd_hit && !wdctrl_reg[`CWL_WD_IRQ_BIT]) |=> (!wdog_reset_out_n)[*8])
    else $error("watchdog reset pulse missing");
  AST_KEY: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_en && adr_in[4:2] == `CWL_ADR_WDKEY && dat_in[7:0] == `CWL_KEY_ARM)
    ##3 (wr_en && adr_in[4:2] == `CWL_ADR_WDKEY && dat_in[7:0] == `CWL_KEY_FIRE)
    |=> wd_cnt_reg == 8'h00) else $error("key sequence did not clear");
  AST_HALT: assert property (@(posedge clk_in) disable iff (rst_in || dbg_reset_in)
    (state_reg == cwl_pkg::CWL_HALT) |-> (!osc_run_out && !wd_run))
    else $error("halt left oscillator running");
  AST_STANDBY: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == cwl_pkg::CWL_STANDBY)
    |-> (!periph_run_out && !system_clock_out && osc_run_out))
    else $error("standby clocks wrong");
  AST_IDLE: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == cwl_pkg::CWL_IDLE && osc_tick_in && !clock_lost_in)
    |-> (system_clock_out && periph_run_out)) else $error("idle stopped clocks");
  AST_LPSEL: assert property (@(posedge clk_in) disable iff (rst_in || dbg_reset_in)
    (state_reg == cwl_pkg::CWL_NORMAL && idle_exec_in && lowpower_select == 2'b01)
    |=> state_reg == cwl_pkg::CWL_STANDBY) else $error("standby not entered");
  AST_QUAL: assert property (@(posedge clk_in) disable iff (rst_in || dbg_reset_in)
    (state_reg == cwl_pkg::CWL_STANDBY && qual_cnt_reg != qual_len)
    |=> state_reg == cwl_pkg::CWL_STANDBY) else $error("unqualified wake");
  AST_HALT_EXIT: assert property (@(posedge clk_in) disable iff (rst_in || dbg_reset_in)
    (state_reg == cwl_pkg::CWL_HALT && ext_nonmaskable_irq_n_in)
    |=> state_reg == cwl_pkg::CWL_HALT) else $error("halt left without nmi");
  COV_EXPIRE: cover property (@(posedge clk_in) wd_hit);
  COV_STANDBY_WAKE: cover property (@(posedge clk_in)
    state_reg == cwl_pkg::CWL_STANDBY ##1 state_reg == cwl_pkg::CWL_NORMAL);
  COV_LIMP: cover property (@(posedge clk_in) limp_mode_out && system_clock_out);
  COV_HALT_WAKE: cover property (@(posedge clk_in)
    state_reg == cwl_pkg::CWL_HALT ##1 state_reg == cwl_pkg::CWL_NORMAL);
endmodule

// >>> rtl/cwl_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CWL_REGS_SVH
`define CWL_REGS_SVH
`define CWL_ADR_PLL      3'h0
`define CWL_ADR_LPCTRL   3'h1
`define CWL_ADR_WAKESEL  3'h2
`define CWL_ADR_WDCTRL   3'h3
`define CWL_ADR_WDKEY    3'h4
`define CWL_ADR_WDCNT    3'h5
`define CWL_ADR_STATUS   3'h6
`define CWL_RATIO_RST    4'h0
`define CWL_RATIO_MAX    4'ha
`define CWL_LPCTRL_RST   8'h04
`define CWL_LPSEL_LSB    0
`define CWL_QUAL_LSB     2
`define CWL_WAKESEL_RST  16'h0000
`define CWL_WDCTRL_RST   2'h1
`define CWL_WD_EN_BIT    0
`define CWL_WD_IRQ_BIT   1
`define CWL_KEY_ARM      8'h55
`define CWL_KEY_FIRE     8'haa
`define CWL_WD_MAX       8'hff
`define CWL_WD_PULSE     512
`define CWL_SETTLE_CYC   131072
`define CWL_CLK_HZ       40000000
`define CWL_LIMP_HZ      2000000
`define CWL_LIMP_DIV     (`CWL_CLK_HZ / `CWL_LIMP_HZ)
`endif

// >>> rtl/cwl_pkg.sv
// types shared by the clock, watchdog and low-power block
package cwl_pkg;
  typedef enum logic [1:0] {
    CWL_NORMAL,
    CWL_IDLE,
    CWL_STANDBY,
    CWL_HALT
  } cwl_lpm_e;
  // active-low standby wake candidates
  typedef struct packed {
    logic       can_receive_pin;
    logic       uart_b_receive;
    logic       uart_a_receive;
    logic [5:0] compare_trip_inputs;
    logic [3:0] timer_trip_inputs;
    logic       ext_irq_one;
  } cwl_wake_s;
endpackage

// >>> verif/cwl_top_bench.sv
// self-checking bench for the clock, watchdog and low-power block
`include "cwl_regs.svh"
module cwl_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE = 64;
  localparam int PULSE  = 16;
  logic               clk_in, rst_in, dbg_reset_in, cyc_in, stb_in, we_in;
  logic        [4:0]  adr_in;
  logic        [3:0]  sel_in, sysclk_halves_out;
  logic        [31:0] dat_in, dat_out, q, q2;
  logic               ack_out, pll_disable_pin_n_in, osc_tick_in, clock_lost_in;
  logic               idle_exec_in, irq_pending_in, ext_nonmaskable_irq_n_in;
  cwl_pkg::cwl_wake_s wake_in;
  logic               system_clock_out, limp_mode_out, osc_run_out, periph_run_out;
  logic               pin_hold_out, pll_settled_out, wdog_reset_out_n, wdog_wake_irq_n;
  logic               wdog_irq_to_expander_out, wake_out;
  logic        [1:0]  lpm_state_out;
  logic        [31:0] exp_r;
  int                 mismatches, checked, wakes, n, k;

  cwl_top #(.SETTLE_CYC(SETTLE), .PULSE_LEN(PULSE)) i_cwl_top (
    .clk_in(clk_in), .rst_in(rst_in), .dbg_reset_in(dbg_reset_in), .cyc_in(cyc_in),
    .stb_in(stb_in), .we_in(we_in), .adr_in(adr_in), .sel_in(sel_in), .dat_in(dat_in),
    .dat_out(dat_out), .ack_out(ack_out), .pll_disable_pin_n_in(pll_disable_pin_n_in),
    .osc_tick_in(osc_tick_in), .clock_lost_in(clock_lost_in), .idle_exec_in(idle_exec_in),
    .irq_pending_in(irq_pending_in), .ext_nonmaskable_irq_n_in(ext_nonmaskable_irq_n_in),
    .wake_in(wake_in), .system_clock_out(system_clock_out),
    .sysclk_halves_out(sysclk_halves_out), .limp_mode_out(limp_mode_out),
    .osc_run_out(osc_run_out), .periph_run_out(periph_run_out), .pin_hold_out(pin_hold_out),
    .pll_settled_out(pll_settled_out), .wdog_reset_out_n(wdog_reset_out_n),
    .wdog_wake_irq_n(wdog_wake_irq_n), .wdog_irq_to_expander_out(wdog_irq_to_expander_out),
    .wake_out(wake_out), .lpm_state_out(lpm_state_out));

  // 40 MHz clock
  initial clk_in = 1'b0;
  always #12.5 clk_in = ~clk_in;

  // oscillator tick every second clock, wake pulse counter
  always @(posedge clk_in) begin
    osc_tick_in <= ~osc_tick_in;
    if (wake_out === 1'b1) wakes++;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic bus(input logic [2:0] w, input logic wr, input logic [31:0] d,
                     output logic [31:0] r);
    int t;
    t = 0;
    @(posedge clk_in);
    cyc_in <= 1'b1;
    stb_in <= 1'b1;
    we_in  <= wr;
    adr_in <= {w, 2'b00};
    dat_in <= d;
    sel_in <= 4'hf;
    @(posedge clk_in);
    while (ack_out !== 1'b1 && t < 64) begin
      t++;
      @(posedge clk_in);
    end
    r = dat_out;
    cyc_in <= 1'b0;
    stb_in <= 1'b0;
    we_in  <= 1'b0;
    if (t >= 64) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [2:0] w, input logic [31:0] d);
    logic [31:0] r;
    bus(w, 1'b1, d, r);
  endtask

  task automatic rd_chk(input logic [2:0] w, input logic [31:0] exp);
    logic [31:0] r;
    bus(w, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic wait_state(input logic [1:0] s);
    int t;
    t = 0;
    while (lpm_state_out !== s && t < 100) begin
      @(posedge clk_in);
      #1;
      t++;
    end
    chk({30'h0, lpm_state_out}, {30'h0, s});
  endtask

  // wait for the watchdog wake interrupt to reach a level
  task automatic wait_irq(input logic lvl);
    int t;
    t = 0;
    while (wdog_wake_irq_n !== lvl && t < 600) begin
      @(posedge clk_in);
      #1;
      t++;
    end
    chk_bit(wdog_wake_irq_n, lvl);
  endtask

  task automatic enter_lp;
    @(posedge clk_in);
    idle_exec_in <= 1'b1;
    @(posedge clk_in);
    idle_exec_in <= 1'b0;
    #1;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    results;
  end

  // main sequence
  initial begin
    {rst_in, pll_disable_pin_n_in, ext_nonmaskable_irq_n_in} = 3'b111;
    {dbg_reset_in, cyc_in, stb_in, we_in, osc_tick_in} = 5'h0;
    {clock_lost_in, idle_exec_in, irq_pending_in} = 3'h0;
    {adr_in, dat_in, sel_in} = {5'h0, 32'h0, 4'hf};
    wake_in = '1;
    {mismatches, checked, wakes} = 0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(`CWL_ADR_PLL, 32'h0);
    rd_chk(`CWL_ADR_LPCTRL, {24'h0, `CWL_LPCTRL_RST});
    rd_chk(`CWL_ADR_WAKESEL, 32'h0);
    rd_chk(`CWL_ADR_WDCTRL, {30'h0, `CWL_WDCTRL_RST});
    rd_chk(3'h7, 32'h0);
    chk({28'h0, sysclk_halves_out}, 32'h1);
    note("reset values");
    wr(`CWL_ADR_WDCTRL, 32'h0);
    exp_r = 32'h0;
    for (int i = 0; i < 16; i++) begin
      wr(`CWL_ADR_PLL, i);
      if (i <= 10) exp_r = i;
      rd_chk(`CWL_ADR_PLL, exp_r);
      chk({28'h0, sysclk_halves_out}, (exp_r == 0) ? 32'h1 : exp_r);
    end
    @(posedge clk_in) dbg_reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    dbg_reset_in <= 1'b0;
    rd_chk(`CWL_ADR_PLL, 32'ha);
    repeat (2 * SETTLE + 8) @(posedge clk_in);
    chk_bit(pll_settled_out, 1'b1);
    note("pll ratio");
    wr(`CWL_ADR_WDCTRL, 32'h1);
    wr(`CWL_ADR_WDKEY, {24'h0, `CWL_KEY_ARM});
    wr(`CWL_ADR_WDKEY, {24'h0, `CWL_KEY_FIRE});
    bus(`CWL_ADR_WDCNT, 1'b0, 32'h0, q);
    chk_bit(q < 32'h4, 1'b1);
    repeat (100) @(posedge clk_in);
    wr(`CWL_ADR_WDKEY, {24'h0, `CWL_KEY_ARM});
    wr(`CWL_ADR_WDKEY, 32'h12);
    wr(`CWL_ADR_WDKEY, {24'h0, `CWL_KEY_FIRE});
    bus(`CWL_ADR_WDCNT, 1'b0, 32'h0, q);
    chk_bit(q >= 32'd40, 1'b1);
    @(posedge clk_in) clock_lost_in <= 1'b1;
    bus(`CWL_ADR_WDCNT, 1'b0, 32'h0, q);
    repeat (40) @(posedge clk_in);
    bus(`CWL_ADR_WDCNT, 1'b0, 32'h0, q2);
    chk(q2, q);
    chk_bit(limp_mode_out, 1'b1);
    n = 0;
    repeat (200) begin
      @(posedge clk_in);
      #1;
      if (system_clock_out === 1'b1) n++;
    end
    chk(n, 32'd10);
    @(posedge clk_in) clock_lost_in <= 1'b0;
    note("watchdog key and clock loss");
    n = 0;
    while (wdog_reset_out_n !== 1'b0 && n < 1200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk_bit(n < 1200, 1'b1);
    k = 0;
    while (wdog_reset_out_n === 1'b0 && n < 2000) begin
      if (osc_tick_in === 1'b1) k++;
      @(posedge clk_in);
      #1;
      n++;
    end
    chk(k, PULSE);
    wr(`CWL_ADR_WDCTRL, 32'h0);
    note("watchdog expiry");
    wr(`CWL_ADR_LPCTRL, 32'h04);
    enter_lp;
    chk({30'h0, lpm_state_out}, 32'h1);
    chk_bit(periph_run_out & osc_run_out, 1'b1);
    @(posedge clk_in) irq_pending_in <= 1'b1;
    wait_state(2'h0);
    @(posedge clk_in) irq_pending_in <= 1'b0;
    wr(`CWL_ADR_LPCTRL, 32'h11);
    wr(`CWL_ADR_WAKESEL, 32'h1);
    enter_lp;
    chk({30'h0, lpm_state_out}, 32'h2);
    chk({29'h0, periph_run_out, osc_run_out, pin_hold_out}, 32'h3);
    @(posedge clk_in) wake_in.ext_irq_one <= 1'b0;
    repeat (2) @(posedge clk_in);
    wake_in.ext_irq_one <= 1'b0 ^ 1'b1;
    wake_in.timer_trip_inputs <= 4'h0;
    repeat (20) @(posedge clk_in);
    wake_in.timer_trip_inputs <= 4'hf;
    #1;
    chk({30'h0, lpm_state_out}, 32'h2);
    @(posedge clk_in) wake_in.ext_irq_one <= 1'b0;
    wait_state(2'h0);
    @(posedge clk_in) wake_in.ext_irq_one <= 1'b1;
    #1;
    chk(wakes, 32'd2);
    note("idle and standby");
    wr(`CWL_ADR_LPCTRL, 32'h12);
    enter_lp;
    chk({30'h0, lpm_state_out}, 32'h3);
    chk_bit(osc_run_out, 1'b0);
    @(posedge clk_in) irq_pending_in <= 1'b1;
    wake_in.ext_irq_one <= 1'b0;
    repeat (20) @(posedge clk_in);
    #1;
    chk({30'h0, lpm_state_out}, 32'h3);
    @(posedge clk_in) ext_nonmaskable_irq_n_in <= 1'b0;
    wait_state(2'h0);
    @(posedge clk_in) {ext_nonmaskable_irq_n_in, irq_pending_in} <= 2'b10;
    wake_in.ext_irq_one <= 1'b1;
    #1;
    chk(wakes, 32'd3);
    note("halt");
    wr(`CWL_ADR_LPCTRL, 32'h04);
    wr(`CWL_ADR_WDCTRL, 32'h3);
    enter_lp;
    chk({30'h0, lpm_state_out}, 32'h1);
    wait_irq(1'b0);
    chk_bit(wdog_irq_to_expander_out & wdog_reset_out_n, 1'b1);
    wait_state(2'h0);
    wait_irq(1'b1);
    wr(`CWL_ADR_WAKESEL, 32'h4000);
    wr(`CWL_ADR_LPCTRL, 32'h05);
    enter_lp;
    chk({30'h0, lpm_state_out}, 32'h2);
    wait_irq(1'b0);
    wait_state(2'h0);
    wr(`CWL_ADR_WDCTRL, 32'h0);
    chk(wakes, 32'd5);
    note("watchdog wake");
    @(posedge clk_in) {rst_in, pll_disable_pin_n_in} <= 2'b10;
    repeat (4) @(posedge clk_in);
    {rst_in, pll_disable_pin_n_in} <= 2'b01;
    @(posedge clk_in);
    #1;
    chk({28'h0, sysclk_halves_out}, 32'h2);
    rd_chk(`CWL_ADR_PLL, 32'h0);
    rd_chk(`CWL_ADR_STATUS, 32'h8);
    note("disable strap");
    results;
  end
endmodule
